// ===== rtl/sfpi_consts.vh
`ifndef SFPI_CONSTS_VH
`define SFPI_CONSTS_VH
// =====================================================================
// Link pin levels and byte layout.
// =====================================================================
// Bytes travel most significant bit first.
`define SFPI_BYTE_W 8
// Bit counter value at a byte boundary.
`define SFPI_BIT_CNT_RST 3'h0
// Last bit index of a byte.
`define SFPI_BIT_LAST 3'h7
// Default depth of the inbound byte FIFO.
`define SFPI_FIFO_DEPTH 16
// Idle output level of the serial output register after reset.
`define SFPI_OUT_RST 1'h0
// Lane width codes for the transfer mode input.
`define SFPI_MODE_SINGLE 2'h0
`define SFPI_MODE_DUAL_OUT 2'h1
`define SFPI_MODE_DUAL_IN 2'h2
`endif

// ===== rtl/sfpi_fifo.v
`timescale 1ns/1ps
// =====================================================================
// Small synchronous FIFO with valid/ready on both sides.
// =====================================================================
module sfpi_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_wr_valid,
    output wire o_wr_ready,
    input wire [WIDTH-1:0] i_wr_data,
    output wire o_rd_valid,
    input wire i_rd_ready,
    output reg [WIDTH-1:0] o_rd_data
);
    // Storage array; read data come out of a register.
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    // Pointers and occupancy count.
    reg [AW-1:0] wr_ptr_q;
    reg [AW-1:0] rd_ptr_q;
    reg [AW:0] count_q;
    // Output register holds a word.
    reg out_valid_q;
    wire do_wr;
    wire do_rd;
    wire load_out;

    assign o_wr_ready = (count_q != DEPTH[AW:0]);
    assign do_wr = i_wr_valid && o_wr_ready;
    // Refill the output register when it is empty or being drained.
    assign load_out = (count_q != {(AW+1){1'b0}}) &&
                      (!out_valid_q || i_rd_ready);
    assign do_rd = load_out;
    assign o_rd_valid = out_valid_q;

    // Array write; no reset needed on data storage.
    always @(posedge i_clk) begin
        if (do_wr) begin
            mem_q[wr_ptr_q] <= i_wr_data;
        end
    end

    // Pointer, count and output register updates.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
            out_valid_q <= 1'b0;
            o_rd_data <= {WIDTH{1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (do_rd) begin
                rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
                o_rd_data <= mem_q[rd_ptr_q];
                out_valid_q <= 1'b1;
            end else if (i_rd_ready) begin
                out_valid_q <= 1'b0;
            end
            case ({do_wr, do_rd})
                2'b10: count_q <= count_q + {{AW{1'b0}}, 1'b1};
                2'b01: count_q <= count_q - {{AW{1'b0}}, 1'b1};
                default: count_q <= count_q;
            endcase
        end
    end
endmodule // sfpi_fifo

// ===== rtl/sfpi_link.v
`timescale 1ns/1ps
`include "sfpi_consts.vh"
// Contract
// - Works in clock mode 0 and 3.
// - Deselect: standby, serial output tristated.
// - Deselected: serial input ignored entirely.
// - Standby waits for internal operation completion.
// - Input bits sampled on rising clock.
// - Output bits updated on falling clock; mode 0 drives the first bit at frame start.
// - Input on single lane unless dual command.
// - Dual read drives two bits per fall.
// - Dual program samples two bits per rise.
// - Hold freezes clock, input; output tristated.
module sfpi_link #(
    parameter FIFO_DEPTH = `SFPI_FIFO_DEPTH,
    parameter FIFO_AW = 4
) (
    input wire i_core_clk,
    input wire i_resetn,
    // Link pins from the host.
    input wire i_sel_n,
    input wire i_sclk,
    input wire i_hold_n,
    input wire i_lane0_in,
    output reg o_lane0_out,
    output reg o_lane0_oe,
    input wire i_lane1_in,
    output reg o_lane1_out,
    output reg o_lane1_oe,
    // Transfer mode chosen by the command decoder.
    input wire [1:0] i_mode,
    // Internal self-timed operation in progress.
    input wire i_busy,
    // Received bytes towards the core.
    output reg o_rx_valid,
    input wire i_rx_ready,
    output reg [7:0] o_rx_data,
    // Transmit byte supply from the core.
    input wire [7:0] i_tx_data,
    output reg o_tx_take,
    // Frame status towards the core.
    output reg o_frame_start,
    output reg o_frame_end,
    output reg o_standby,
    output reg o_overflow
);
    // =================================================================
    // Reset release and pin synchronisers
    // =================================================================
    // Reset is released through two flops.
    reg rst_m_q;
    reg rst_q;
    always @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_m_q <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_q <= rst_m_q;
        end
    end

    // First and second stages for each pin; first stage read only here.
    reg [4:0] pin_m_q;
    reg [4:0] pin_s_q;
    // Delayed copy of the synchronised pins for edge detection.
    reg [4:0] pin_p_q;
    always @(posedge i_core_clk or negedge rst_q) begin
        if (!rst_q) begin
            pin_m_q <= 5'h07;
            pin_s_q <= 5'h07;
            pin_p_q <= 5'h07;
        end else begin
            pin_m_q <= {i_lane1_in, i_lane0_in, i_hold_n, i_sclk, i_sel_n};
            pin_s_q <= pin_m_q;
            pin_p_q <= pin_s_q;
        end
    end

    // Named synchronised levels.
    wire sel_n = pin_s_q[0];
    wire sclk = pin_s_q[1];
    wire hold_n = pin_s_q[2];
    wire lane0 = pin_s_q[3];
    wire lane1 = pin_s_q[4];
    // Selected and not on hold; the clock matters only then.
    wire active = !sel_n && hold_n;
    // Edges are taken from synced copies, so either idle level works.
    wire rise = active && sclk && !pin_p_q[1];
    wire fall = active && !sclk && pin_p_q[1];
    wire sel_fall = !sel_n && pin_p_q[0];
    wire sel_rise = sel_n && !pin_p_q[0];

    // =================================================================
    // Receive shifter
    // =================================================================
    // Bit count within the current byte and the shift register.
    reg [2:0] bit_q;
    reg [7:0] shift_q;
    reg [7:0] rx_byte_q;
    reg rx_push_q;
    wire fifo_ready;
    wire dual_in = (i_mode == `SFPI_MODE_DUAL_IN);
    wire [7:0] sh_one = {shift_q[6:0], lane0};
    wire [7:0] sh_two = {shift_q[5:0], lane1, lane0};
    // Byte closes after 8 single or 4 dual samples.
    wire byte_done = dual_in ? (bit_q[1:0] == 2'h3)
                             : (bit_q == `SFPI_BIT_LAST);

    // Sampling on rising clock edges, MSB first.
    always @(posedge i_core_clk or negedge rst_q) begin
        if (!rst_q) begin
            bit_q <= `SFPI_BIT_CNT_RST;
            shift_q <= 8'h00;
            rx_byte_q <= 8'h00;
            rx_push_q <= 1'b0;
            o_overflow <= 1'b0;
        end else begin
            rx_push_q <= 1'b0;
            if (sel_fall || sel_n) begin
                // Frame edges realign to a byte boundary.
                bit_q <= `SFPI_BIT_CNT_RST;
            end else if (rise && i_mode != `SFPI_MODE_DUAL_OUT) begin
                if (dual_in) begin
                    shift_q <= sh_two;
                end else begin
                    shift_q <= sh_one;
                end
                bit_q <= bit_q + 3'h1;
                if (byte_done) begin
                    bit_q <= `SFPI_BIT_CNT_RST;
                    rx_byte_q <= dual_in ? sh_two : sh_one;
                    rx_push_q <= 1'b1;
                    // Byte lost when the core stalls too long.
                    if (!fifo_ready) begin
                        o_overflow <= 1'b1;
                    end
                end
            end
            if (sel_fall) begin
                o_overflow <= 1'b0;
            end
        end
    end

    // Received bytes buffer; the core may stall the drain side.
    wire fifo_valid;
    wire [7:0] fifo_data;
    sfpi_fifo #(
        .WIDTH(`SFPI_BYTE_W),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .i_clk(i_core_clk),
        .i_rst_n(rst_q),
        .i_wr_valid(rx_push_q),
        .o_wr_ready(fifo_ready),
        .i_wr_data(rx_byte_q),
        .o_rd_valid(fifo_valid),
        .i_rd_ready(i_rx_ready && !o_rx_valid),
        .o_rd_data(fifo_data)
    );

    // Output stage registered so every port is a flop.
    always @(posedge i_core_clk or negedge rst_q) begin
        if (!rst_q) begin
            o_rx_valid <= 1'b0;
            o_rx_data <= 8'h00;
        end else if (o_rx_valid) begin
            o_rx_valid <= 1'b0;
        end else if (fifo_valid && i_rx_ready) begin
            o_rx_valid <= 1'b1;
            o_rx_data <= fifo_data;
        end
    end

    // =================================================================
    // Transmit shifter
    // =================================================================
    reg [7:0] tx_q;
    reg [2:0] tx_bit_q;
    wire dual_out = (i_mode == `SFPI_MODE_DUAL_OUT);

    // Drive on falling clock edges; the byte is fetched at its first bit.
    // In mode 0 no fall comes before the first rise, so the frame start
    // stands in for that fall; otherwise every byte would leave one bit
    // late and a mode 0 host would read shifted data.
    always @(posedge i_core_clk or negedge rst_q) begin
        if (!rst_q) begin
            tx_q <= 8'h00;
            tx_bit_q <= `SFPI_BIT_CNT_RST;
            o_tx_take <= 1'b0;
            o_lane0_out <= `SFPI_OUT_RST;
            o_lane1_out <= `SFPI_OUT_RST;
        end else begin
            o_tx_take <= 1'b0;
            if (sel_n) begin
                tx_bit_q <= `SFPI_BIT_CNT_RST;
            end else if (fall || (sel_fall && !sclk)) begin
                if (tx_bit_q == `SFPI_BIT_CNT_RST) begin
                    o_tx_take <= 1'b1;
                    if (dual_out) begin
                        // Two bits per falling edge, lane1 carries MSB.
                        o_lane1_out <= i_tx_data[7];
                        o_lane0_out <= i_tx_data[6];
                        tx_q <= {i_tx_data[5:0], 2'h0};
                    end else begin
                        o_lane1_out <= i_tx_data[7];
                        tx_q <= {i_tx_data[6:0], 1'h0};
                    end
                end else if (dual_out) begin
                    o_lane1_out <= tx_q[7];
                    o_lane0_out <= tx_q[6];
                    tx_q <= {tx_q[5:0], 2'h0};
                end else begin
                    o_lane1_out <= tx_q[7];
                    tx_q <= {tx_q[6:0], 1'h0};
                end
                if (dual_out) begin
                    tx_bit_q <= (tx_bit_q == 3'h3) ? `SFPI_BIT_CNT_RST
                                                   : tx_bit_q + 3'h1;
                end else begin
                    tx_bit_q <= tx_bit_q + 3'h1;
                end
            end
        end
    end

    // =================================================================
    // Output enables, frame status and standby
    // =================================================================
    // Enables drop while deselected or on hold; lane0 drives in dual read.
    always @(posedge i_core_clk or negedge rst_q) begin
        if (!rst_q) begin
            o_lane0_oe <= 1'b0;
            o_lane1_oe <= 1'b0;
            o_frame_start <= 1'b0;
            o_frame_end <= 1'b0;
            o_standby <= 1'b1;
        end else begin
            o_lane1_oe <= active && !dual_in;
            o_lane0_oe <= active && dual_out;
            o_frame_start <= sel_fall;
            o_frame_end <= sel_rise;
            // Standby only once deselected and nothing is running.
            o_standby <= sel_n && !i_busy;
        end
    end
endmodule // sfpi_link

// ===== dv/sfpi_link_props.sv
`timescale 1ns/1ps
`include "sfpi_consts.vh"
// ============================================================
// Pin-level checks of the link front end.
// ============================================================
module sfpi_link_props (
    input wire i_core_clk,
    input wire i_resetn,
    input wire i_sel_n,
    input wire i_sclk,
    input wire i_hold_n,
    input wire [1:0] i_mode,
    input wire i_busy,
    input wire o_lane0_oe,
    input wire o_lane1_oe,
    input wire o_lane1_out,
    input wire o_standby,
    input wire o_frame_start,
    input wire o_frame_end
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    // Six cycles cover the pin synchroniser and the output register.
    sequence s_desel; i_sel_n [*6]; endsequence
    sequence s_held; !i_hold_n [*6]; endsequence
    sequence s_busy; i_busy [*6]; endsequence
    sequence s_idle; (i_sel_n && !i_busy) [*6]; endsequence
    a_desel_tristate:
        assert property (s_desel |-> !o_lane0_oe && !o_lane1_oe)
        else $error("Lane driven while deselected.");
    a_hold_tristate:
        assert property (s_held |-> !o_lane0_oe && !o_lane1_oe)
        else $error("Lane driven while held.");
    a_busy_no_standby:
        assert property (s_busy |-> !o_standby)
        else $error("Standby entered while busy.");
    a_idle_standby:
        assert property (s_idle |-> o_standby)
        else $error("Standby missing while idle.");
    a_start_cause:
        assert property (o_frame_start |-> !$past(i_sel_n, 2))
        else $error("Frame start without select low.");
    a_end_cause:
        assert property (o_frame_end |-> $past(i_sel_n, 2))
        else $error("Frame end without select high.");
    a_lane0_dual:
        assert property (o_lane0_oe |-> i_mode == `SFPI_MODE_DUAL_OUT)
        else $error("Lane0 driven outside dual read.");
    // The output may only move a few cycles after the clock pin fell.
    a_out_on_fall:
        assert property ($changed(o_lane1_out) && o_lane1_oe
            && $past(o_lane1_oe) && !$past(i_sel_n, 4) |-> !$past(i_sclk, 2))
        else $error("Output moved without a falling clock.");
endmodule // sfpi_link_props
bind sfpi_link sfpi_link_props sfpi_link_props_i (.i_core_clk(i_core_clk),
    .i_resetn(i_resetn), .i_sel_n(i_sel_n), .i_sclk(i_sclk),
    .i_hold_n(i_hold_n), .i_mode(i_mode), .i_busy(i_busy),
    .o_lane0_oe(o_lane0_oe), .o_lane1_oe(o_lane1_oe),
    .o_lane1_out(o_lane1_out), .o_standby(o_standby),
    .o_frame_start(o_frame_start), .o_frame_end(o_frame_end));

// ===== dv/sfpi_host.sv
`timescale 1ns/1ps
// ============================================================
// Host controller model: select, serial clock and data lanes.
// ============================================================
module sfpi_host (
    input wire i_clk,
    input wire i_lane0,
    input wire i_lane1,
    output reg o_sel_n = 1'h1,
    output reg o_sclk = 1'h0,
    output reg o_l0 = 1'h0,
    output reg o_l0_oe = 1'h0,
    output reg o_l1 = 1'h0,
    output reg o_l1_oe = 1'h0
);
    task cyc(input integer n);
        repeat (n) @(posedge i_clk);
    endtask
    // Clock idle level is set before select moves, never with it.
    // One cycle passes first, so the clock edge that a shift has just
    // driven is never driven a second time in the same step.
    task sel(input v, input c);
        begin
            cyc(1);
            o_sclk <= c;
            cyc(2);
            o_sel_n <= v;
            cyc(6);
        end
    endtask
    // Mode 1 reads two lanes; mode 2 writes two lanes per clock.
    task shift(input [7:0] d, input integer n, input c, input [1:0] m,
        output [7:0] r);
        integer k;
        begin
            r = 8'h00;
            o_l0_oe <= (m != 2'h1);
            o_l1_oe <= (m == 2'h2);
            for (k = 0; k < n; k = k + 1) begin
                if (c)
                    o_sclk <= 1'h0;
                o_l1 <= d[7];
                o_l0 <= (m == 2'h2) ? d[6] : d[7];
                d = (m == 2'h2) ? d << 2 : d << 1;
                cyc(4);
                o_sclk <= 1'h1;
                cyc(4);
                if (m == 2'h1)
                    r = {r[5:0], i_lane1, i_lane0};
                else
                    r = {r[6:0], i_lane1};
                if (!c)
                    o_sclk <= 1'h0;
            end
        end
    endtask
endmodule // sfpi_host

// ===== dv/tb.sv
`timescale 1ns/1ps
// ============================================================
// Self-checking bench of the link front end.
// ============================================================
module tb;
    reg clk = 1'h0;
    reg resetn = 1'h0;
    reg hold_n = 1'h1;
    reg [1:0] mode = 2'h0;
    reg busy = 1'h0;
    reg rx_ready = 1'h1;
    reg [7:0] tx_data = 8'hA5;
    reg [7:0] r;
    reg [7:0] q[$];
    integer fails = 0;
    integer n_tests = 0;
    wire sel_n, sclk, h0, h0_oe, h1, h1_oe;
    wire l0_oe, l0_out, l1_oe, l1_out, rx_valid, ovf, stby;
    wire [7:0] rx_data;
    wire tx_take;
    // Count of transmit byte fetches seen from the link.
    reg [7:0] n_take = 8'h00;
    // Released lines show the inverse of their last level.
    wire lane0 = l0_oe ? l0_out : (h0_oe ? h0 : ~h0);
    wire lane1 = l1_oe ? l1_out : (h1_oe ? h1 : ~h1);
    always #10 clk = ~clk;
    always @(posedge clk) if (rx_valid === 1'h1) q.push_back(rx_data);
    always @(posedge clk) if (tx_take === 1'h1) n_take <= n_take + 8'h01;
    sfpi_link sfpi_link_i (.i_core_clk(clk), .i_resetn(resetn),
        .i_sel_n(sel_n), .i_sclk(sclk), .i_hold_n(hold_n),
        .i_lane0_in(lane0), .o_lane0_out(l0_out), .o_lane0_oe(l0_oe),
        .i_lane1_in(lane1), .o_lane1_out(l1_out), .o_lane1_oe(l1_oe),
        .i_mode(mode), .i_busy(busy), .o_rx_valid(rx_valid),
        .i_rx_ready(rx_ready), .o_rx_data(rx_data), .i_tx_data(tx_data),
        .o_tx_take(tx_take), .o_frame_start(), .o_frame_end(),
        .o_standby(stby), .o_overflow(ovf));
    sfpi_host sfpi_host_i (.i_clk(clk), .i_lane0(lane0), .i_lane1(lane1),
        .o_sel_n(sel_n), .o_sclk(sclk), .o_l0(h0), .o_l0_oe(h0_oe),
        .o_l1(h1), .o_l1_oe(h1_oe));
    task cyc(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task sel(input v, input c);
        sfpi_host_i.sel(v, c);
    endtask
    task shf(input [7:0] d, input integer n, input c, input [1:0] m);
        sfpi_host_i.shift(d, n, c, m, r);
    endtask
    task chk(input [7:0] seen, input [7:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("wrong value at %0t: %h vs %h", $time, seen, exp);
            end
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d, mismatches %0d", n_tests, fails);
            if (fails == 0 && n_tests > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // A byte that never shows within the bound ends the run.
    task take(input [7:0] exp);
        integer k;
        begin
            for (k = 0; k < 300 && q.size() == 0; k = k + 1)
                @(posedge clk);
            if (q.size() == 0) begin
                fails = fails + 1;
                print_verdict;
            end
            chk(q.pop_front(), exp);
        end
    endtask
    task t_realign;
        begin
            sel(1'h0, 1'h0);
            shf(8'hE0, 3, 1'h0, 2'h0);
            sel(1'h1, 1'h0);
            sel(1'h0, 1'h0);
            shf(8'h3C, 8, 1'h0, 2'h0);
            shf(8'h81, 8, 1'h0, 2'h0);
            chk(r, 8'hA5);
            sel(1'h1, 1'h0);
            take(8'h3C);
            take(8'h81);
        end
    endtask
    // Eight falls of one mode 3 byte fetch exactly one transmit byte.
    task t_read3;
        reg [7:0] t0;
        begin
            t0 = n_take;
            sel(1'h0, 1'h1);
            shf(8'h5A, 8, 1'h1, 2'h0);
            sel(1'h1, 1'h1);
            chk(r, 8'hA5);
            chk(n_take - t0, 8'h01);
            take(8'h5A);
        end
    endtask
    task t_dual;
        begin
            tx_data <= 8'h96;
            mode <= 2'h1;
            sel(1'h0, 1'h1);
            shf(8'h00, 4, 1'h1, 2'h1);
            sel(1'h1, 1'h1);
            chk(r, 8'h96);
            cyc(8);
            q.delete();
            mode <= 2'h2;
            sel(1'h0, 1'h0);
            shf(8'h69, 4, 1'h0, 2'h2);
            sel(1'h1, 1'h0);
            take(8'h69);
            mode <= 2'h0;
        end
    endtask
    task t_desel;
        begin
            shf(8'hFF, 8, 1'h0, 2'h0);
            cyc(8);
            chk({7'h00, q.size() != 0}, 8'h00);
            chk({7'h00, l1_oe}, 8'h00);
            busy <= 1'h1;
            sel(1'h0, 1'h0);
            sel(1'h1, 1'h0);
            chk({7'h00, stby}, 8'h00);
            busy <= 1'h0;
            cyc(8);
            chk({7'h00, stby}, 8'h01);
        end
    endtask
    task t_hold;
        begin
            sel(1'h0, 1'h0);
            shf(8'hA0, 4, 1'h0, 2'h0);
            cyc(2);
            hold_n <= 1'h0;
            cyc(6);
            chk({7'h00, l1_oe}, 8'h00);
            shf(8'hFF, 4, 1'h0, 2'h0);
            // Let the last clock fall settle before the hold ends.
            cyc(2);
            hold_n <= 1'h1;
            cyc(6);
            shf(8'h50, 4, 1'h0, 2'h0);
            sel(1'h1, 1'h0);
            take(8'hA5);
        end
    endtask
    // The core stalls while eighteen bytes arrive, then drains.
    task t_fifo;
        integer k;
        begin
            rx_ready <= 1'h0;
            sel(1'h0, 1'h0);
            for (k = 0; k < 18; k = k + 1)
                shf(k[7:0] + 8'h10, 8, 1'h0, 2'h0);
            sel(1'h1, 1'h0);
            chk({7'h00, ovf}, 8'h01);
            rx_ready <= 1'h1;
            for (k = 0; k < 16; k = k + 1)
                take(k[7:0] + 8'h10);
            cyc(20);
            q.delete();
            sel(1'h0, 1'h0);
            chk({7'h00, ovf}, 8'h00);
            sel(1'h1, 1'h0);
        end
    endtask
    initial begin
        cyc(3);
        resetn <= 1'h1;
        cyc(6);
        t_realign;
        t_read3;
        t_dual;
        t_desel;
        t_hold;
        t_fifo;
        print_verdict;
    end
endmodule // tb
